// ### hw/exirq_pkg.sv
package exirq_pkg;

	// register addresses on the special-function bus
	localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
	localparam logic [7:0] ADDR_PIN_CONFIG = 8'hE4;
	localparam logic [7:0] ADDR_PRIORITY_TWO = 8'hF7;

	// reset values
	localparam logic [7:0] RST_PIN_CONFIG = 8'h01;
	localparam logic [7:0] RST_PRIORITY_TWO = 8'h00;
	localparam logic [1:0] RST_EDGE_MODE = 2'h0;
	localparam logic [7:0] RST_READ_DATA = 8'h00;
	localparam logic [7:0] RST_PIN_SYNC = 8'hFF;

	// timer control register fields held here (the timer bits live elsewhere)
	localparam int BIT_EDGE_A = 0;
	localparam int BIT_PEND_A = 1;
	localparam int BIT_EDGE_B = 2;
	localparam int BIT_PEND_B = 3;

	// pin configuration register fields
	localparam int SEL_A_LSB = 0;
	localparam int BIT_POL_A = 3;
	localparam int SEL_B_LSB = 4;
	localparam int BIT_POL_B = 7;
	localparam int SEL_W = 3;

	// second extended priority register fields
	localparam int BIT_PRIO_CIPHER = 7;
	localparam int BIT_PRIO_ENCODER = 6;
	localparam int BIT_PRIO_DMA = 5;
	localparam int BIT_PRIO_PULSE = 4;
	localparam int BIT_PRIO_SPI1 = 3;
	localparam int BIT_PRIO_RTC_FAIL = 2;
	localparam int BIT_PRIO_MATCH = 1;
	localparam int BIT_PRIO_WARN = 0;

	// sensitivity and polarity decode of one input
	typedef enum logic [3:0] {
		EXIRQ_EDGE_LOW = 4'h1,
		EXIRQ_EDGE_HIGH = 4'h2,
		EXIRQ_LEVEL_LOW = 4'h4,
		EXIRQ_LEVEL_HIGH = 4'h8
	} exirq_mode_e;

	function automatic exirq_mode_e exirq_mode_decode(input logic edge_mode, input logic pol);
		case ({edge_mode, pol})
			2'b10: exirq_mode_decode = EXIRQ_EDGE_LOW;
			2'b11: exirq_mode_decode = EXIRQ_EDGE_HIGH;
			2'b00: exirq_mode_decode = EXIRQ_LEVEL_LOW;
			default: exirq_mode_decode = EXIRQ_LEVEL_HIGH;
		endcase
	endfunction : exirq_mode_decode

endpackage : exirq_pkg

// ### hw/exirq_chan_if.sv
`timescale 1ns/1ps
interface exirq_chan_if;
	logic pin_level;   // synchronised selected pin
	logic edge_mode;   // 1 edge, 0 level
	logic active_high; // polarity
	logic vector_ack;  // cpu vectors to this service routine
	logic sw_wr;       // software writes the pending bit
	logic sw_value;    // value written
	logic pending;     // pending flag

	modport ctrl(output pin_level, output edge_mode, output active_high, output vector_ack,
		output sw_wr, output sw_value, input pending);
	modport chan(input pin_level, input edge_mode, input active_high, input vector_ack,
		input sw_wr, input sw_value, output pending);
endinterface : exirq_chan_if

// ### hw/exirq_channel.sv
`timescale 1ns/1ps
module exirq_channel (
	input wire logic clk,    // system clock
	input wire logic rst_b,  // async reset, active low
	input wire logic clk_en, // freezes state while low
	exirq_chan_if.chan ch    // config in, pending out
);
	import exirq_pkg::*;

	exirq_mode_e mode;
	logic active;
	logic prev_active;
	logic edge_seen;
	logic next_pending;
	logic pend_q;

	// polarity and sensitivity decode
	always_comb begin
		mode = exirq_mode_decode(ch.edge_mode, ch.active_high);
		case (mode)
			EXIRQ_EDGE_LOW, EXIRQ_LEVEL_LOW: active = ~ch.pin_level;
			EXIRQ_EDGE_HIGH, EXIRQ_LEVEL_HIGH: active = ch.pin_level;
			default: active = 1'b0;
		endcase
	end

	// previous level resets active so a pin held active at reset raises no edge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prev_active <= 1'b1;
		end else if (clk_en) begin
			prev_active <= active;
		end
	end

	assign edge_seen = active & ~prev_active;

	// pending flag: a new edge wins over any clear in the same cycle
	always_comb begin
		next_pending = pend_q;
		if (!ch.edge_mode) begin
			next_pending = active;
		end else if (edge_seen) begin
			next_pending = 1'b1;
		end else if (ch.sw_wr) begin
			next_pending = ch.sw_value;
		end else if (ch.vector_ack) begin
			next_pending = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pend_q <= 1'b0;
		end else if (clk_en) begin
			pend_q <= next_pending;
		end
	end

	assign ch.pending = pend_q;

	level_follow_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && !ch.edge_mode |=> pend_q == $past(active))
		else $error("level pending does not follow input");
	edge_set_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && ch.edge_mode && active && !prev_active |=> pend_q)
		else $error("edge did not set pending");
	edge_ack_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && ch.edge_mode && ch.vector_ack && !edge_seen && !ch.sw_wr |=> !pend_q)
		else $error("vectoring did not clear edge pending");
	polarity_low_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && !ch.edge_mode && !ch.active_high && !ch.pin_level |=> pend_q)
		else $error("active low level not seen");
	pend_freeze_a: assert property (@(posedge clk) disable iff (!rst_b)
		!clk_en |=> $stable(pend_q))
		else $error("pending moved while frozen");

endmodule : exirq_channel

// ### hw/exirq_top.sv
`timescale 1ns/1ps
// Overview of operation
// - bit 7 sets cipher engine priority
// - bit 6 sets encoder priority
// - bit 5 sets dma priority
// - bit 4 sets pulse counter priority
// - bit 3 sets second spi priority
// - bit 2 sets rtc oscillator-fail priority
// - bit 1 sets port match priority
// - bit 0 sets supply warning priority
// - each input: own polarity and sensitivity
// - sense and polarity bits decode four modes
// - selected pin watched regardless of crossbar
// - skipped pin belongs to interrupt alone
// - pending flags at control bits 1, 3
// - vectoring clears edge-mode pending flag
// - level mode pending follows active input
// - select codes map port pins
// - polarity bits 7 and 3, zero low
module exirq_top (
	input wire logic clk,                  // system clock, 50 MHz
	input wire logic rst_b,                // async reset, active low
	input wire logic clk_en,               // freezes state while low
	input wire logic [7:0] sfr_addr,       // register address
	input wire logic sfr_wr,               // write strobe
	input wire logic sfr_rd,               // read strobe
	input wire logic [7:0] sfr_wdata,      // write data
	output logic [7:0] sfr_rdata,          // read data, one cycle after strobe
	input wire logic [5:0] port0_pins,     // port 0 pins 0..5
	input wire logic [7:6] port1_pins,     // port 1 pins 6..7
	input wire logic [5:0] skip_p0,        // crossbar skip bits, port 0
	input wire logic [7:6] skip_p1,        // crossbar skip bits, port 1
	input wire logic vector_ack_a,         // cpu vectors to input a routine
	input wire logic vector_ack_b,         // cpu vectors to input b routine
	output logic ext_irq_a_pending,        // pending flag, input a
	output logic ext_irq_b_pending,        // pending flag, input b
	output logic ext_irq_a_exclusive,      // selected pin a is skipped
	output logic ext_irq_b_exclusive,      // selected pin b is skipped
	output logic [7:0] source_priority     // priority bits to arbiter
);
	import exirq_pkg::*;

	logic [7:0] pin_meta;
	logic [7:0] pin_sync;
	logic [1:0] edge_mode;
	logic [7:0] ext_irq_pin_config;
	logic [7:0] extended_priority_two;
	logic [7:0] skip_all;
	logic [1:0] pol;
	logic [1:0] ack;
	logic [1:0] pend;
	logic [SEL_W-1:0] sel [2];
	logic wr_timer_control_reg;
	logic wr_pcfg;
	logic wr_prio;
	logic [7:0] next_rdata;

	// selected pin of the eight candidates; code order matches concatenation
	function automatic logic pin_pick(input logic [7:0] pins, input logic [SEL_W-1:0] code);
		pin_pick = pins[code];
	endfunction : pin_pick

	// register write decode
	assign wr_timer_control_reg = clk_en & sfr_wr & (sfr_addr == ADDR_TIMER_CONTROL);
	assign wr_pcfg = clk_en & sfr_wr & (sfr_addr == ADDR_PIN_CONFIG);
	assign wr_prio = clk_en & sfr_wr & (sfr_addr == ADDR_PRIORITY_TWO);

	// two-flop synchroniser; only the second stage is read by logic
	// resets high, the idle level of the default active-low inputs, so no false request
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_meta <= RST_PIN_SYNC;
			pin_sync <= RST_PIN_SYNC;
		end else if (clk_en) begin
			pin_meta <= {port1_pins, port0_pins};
			pin_sync <= pin_meta;
		end
	end

	// edge or level sensitivity bits of the timer control register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			edge_mode <= RST_EDGE_MODE;
		end else if (wr_timer_control_reg) begin
			edge_mode[0] <= sfr_wdata[BIT_EDGE_A];
			edge_mode[1] <= sfr_wdata[BIT_EDGE_B];
		end
	end

	// pin select and polarity register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ext_irq_pin_config <= RST_PIN_CONFIG;
		end else if (wr_pcfg) begin
			ext_irq_pin_config <= sfr_wdata;
		end
	end

	// priority register; all eight bits writable so every source can be raised
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			extended_priority_two <= RST_PRIORITY_TWO;
		end else if (wr_prio) begin
			extended_priority_two <= sfr_wdata;
		end
	end

	// field extraction
	assign pol[0] = ext_irq_pin_config[BIT_POL_A];
	assign pol[1] = ext_irq_pin_config[BIT_POL_B];
	assign sel[0] = ext_irq_pin_config[SEL_A_LSB +: SEL_W];
	assign sel[1] = ext_irq_pin_config[SEL_B_LSB +: SEL_W];
	assign ack = {vector_ack_b, vector_ack_a};
	assign skip_all = {skip_p1, skip_p0};

	// one detector per input; monitoring never drives the pin
	exirq_chan_if chan [2] ();
	generate
		for (genvar i = 0; i < 2; i++) begin : g_chan
			assign chan[i].pin_level = pin_pick(pin_sync, sel[i]);
			assign chan[i].edge_mode = edge_mode[i];
			assign chan[i].active_high = pol[i];
			assign chan[i].vector_ack = ack[i];
			assign chan[i].sw_wr = wr_timer_control_reg;
			assign chan[i].sw_value = sfr_wdata[(i == 0) ? BIT_PEND_A : BIT_PEND_B];
			assign pend[i] = chan[i].pending;
			exirq_channel u_chan (
				.clk(clk),
				.rst_b(rst_b),
				.clk_en(clk_en),
				.ch(chan[i])
			);
		end
	endgenerate

	assign ext_irq_a_pending = pend[0];
	assign ext_irq_b_pending = pend[1];
	assign source_priority = extended_priority_two;

	// crossbar told which selected pins are dedicated to the interrupt
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ext_irq_a_exclusive <= 1'b0;
			ext_irq_b_exclusive <= 1'b0;
		end else if (clk_en) begin
			ext_irq_a_exclusive <= pin_pick(skip_all, sel[0]);
			ext_irq_b_exclusive <= pin_pick(skip_all, sel[1]);
		end
	end

	// read mux; unmapped addresses and timer bits read as zero
	always_comb begin
		next_rdata = 8'h00;
		case (sfr_addr)
			ADDR_TIMER_CONTROL: begin
				next_rdata[BIT_EDGE_A] = edge_mode[0];
				next_rdata[BIT_PEND_A] = pend[0];
				next_rdata[BIT_EDGE_B] = edge_mode[1];
				next_rdata[BIT_PEND_B] = pend[1];
			end
			ADDR_PIN_CONFIG: next_rdata = ext_irq_pin_config;
			ADDR_PRIORITY_TWO: next_rdata = extended_priority_two;
			default: next_rdata = 8'h00;
		endcase
	end

	// read data held until the next read
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sfr_rdata <= RST_READ_DATA;
		end else if (clk_en && sfr_rd) begin
			sfr_rdata <= next_rdata;
		end
	end

	// priority bits follow the written byte one edge later
	cipher_prio_a: assert property (@(posedge clk) disable iff (!rst_b)
		wr_prio |=> source_priority[BIT_PRIO_CIPHER] == $past(sfr_wdata[BIT_PRIO_CIPHER]))
		else $error("cipher priority not taken");
	encoder_prio_a: assert property (@(posedge clk) disable iff (!rst_b)
		wr_prio && sfr_wdata[BIT_PRIO_ENCODER] |=> source_priority[BIT_PRIO_ENCODER])
		else $error("encoder priority not raised");
	dma_prio_a: assert property (@(posedge clk) disable iff (!rst_b)
		wr_prio && !sfr_wdata[BIT_PRIO_DMA] |=> !source_priority[BIT_PRIO_DMA])
		else $error("dma priority not lowered");
	pulse_prio_a: assert property (@(posedge clk) disable iff (!rst_b)
		!wr_prio |=> $stable(source_priority[BIT_PRIO_PULSE]))
		else $error("pulse counter priority moved without write");
	spi_prio_a: assert property (@(posedge clk) disable iff (!rst_b)
		wr_prio |=> source_priority[BIT_PRIO_SPI1] == $past(sfr_wdata[BIT_PRIO_SPI1]))
		else $error("spi priority not taken");
	rtc_prio_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && sfr_rd && sfr_addr == ADDR_PRIORITY_TWO
		|=> sfr_rdata[BIT_PRIO_RTC_FAIL] == $past(source_priority[BIT_PRIO_RTC_FAIL]))
		else $error("rtc priority readback wrong");
	match_prio_a: assert property (@(posedge clk) disable iff (!rst_b)
		wr_prio |=> source_priority[BIT_PRIO_MATCH] == $past(sfr_wdata[BIT_PRIO_MATCH]))
		else $error("port match priority not taken");
	warn_prio_a: assert property (@(posedge clk) disable iff (!rst_b)
		wr_prio && sfr_wdata[BIT_PRIO_WARN] |=> source_priority[BIT_PRIO_WARN] [*1])
		else $error("supply warning priority not raised");
	pend_read_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && sfr_rd && sfr_addr == ADDR_TIMER_CONTROL
		|=> sfr_rdata[BIT_PEND_A] == $past(pend[0]) && sfr_rdata[BIT_PEND_B] == $past(pend[1]))
		else $error("pending flags read at wrong bits");
	skip_map_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && sel[0] == 3'h6 |=> ext_irq_a_exclusive == $past(skip_p1[6]))
		else $error("dedicated flag wrong for code six");
	pin_sync_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en ##1 clk_en |=> pin_sync[0] == $past(port0_pins[0], 2))
		else $error("synchronised pin lags wrongly");
	level_b_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && !edge_mode[1] && pol[1] && sel[1] == 3'h7 && pin_sync[7]
		|=> ext_irq_b_pending)
		else $error("level high on pin seven not pending");

	// priority bits move only on a write of their own register
	cipher_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		!wr_prio |=> $stable(source_priority[BIT_PRIO_CIPHER]))
		else $error("cipher priority moved without write");
	encoder_low_a: assert property (@(posedge clk) disable iff (!rst_b)
		wr_prio && !sfr_wdata[BIT_PRIO_ENCODER] |=> !source_priority[BIT_PRIO_ENCODER])
		else $error("encoder priority not lowered");
	dma_high_a: assert property (@(posedge clk) disable iff (!rst_b)
		wr_prio && sfr_wdata[BIT_PRIO_DMA] |=> source_priority[BIT_PRIO_DMA])
		else $error("dma priority not raised");
	pulse_take_a: assert property (@(posedge clk) disable iff (!rst_b)
		wr_prio |=> source_priority[BIT_PRIO_PULSE] == $past(sfr_wdata[BIT_PRIO_PULSE]))
		else $error("pulse counter priority not taken");
	spi_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		!wr_prio |=> $stable(source_priority[BIT_PRIO_SPI1]))
		else $error("spi priority moved without write");
	rtc_take_a: assert property (@(posedge clk) disable iff (!rst_b)
		wr_prio |=> source_priority[BIT_PRIO_RTC_FAIL] == $past(sfr_wdata[BIT_PRIO_RTC_FAIL]))
		else $error("rtc priority not taken");
	match_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		!wr_prio |=> $stable(source_priority[BIT_PRIO_MATCH]))
		else $error("port match priority moved without write");
	warn_low_a: assert property (@(posedge clk) disable iff (!rst_b)
		wr_prio && !sfr_wdata[BIT_PRIO_WARN] |=> !source_priority[BIT_PRIO_WARN])
		else $error("supply warning priority not lowered");
	prio_read_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && sfr_rd && sfr_addr == ADDR_PRIORITY_TWO
		|=> sfr_rdata == $past(source_priority))
		else $error("priority readback differs from arbiter copy");

	// configuration fields land where the sense and polarity decode expects them
	pol_a_take_a: assert property (@(posedge clk) disable iff (!rst_b)
		wr_pcfg |=> pol[0] == $past(sfr_wdata[BIT_POL_A]))
		else $error("input a polarity not taken");
	pol_b_take_a: assert property (@(posedge clk) disable iff (!rst_b)
		wr_pcfg |=> pol[1] == $past(sfr_wdata[BIT_POL_B]))
		else $error("input b polarity not taken");
	sel_take_a: assert property (@(posedge clk) disable iff (!rst_b)
		wr_pcfg |=> sel[0] == $past(sfr_wdata[SEL_A_LSB +: SEL_W])
		&& sel[1] == $past(sfr_wdata[SEL_B_LSB +: SEL_W]))
		else $error("pin select fields not taken");
	edge_take_a: assert property (@(posedge clk) disable iff (!rst_b)
		wr_timer_control_reg |=> edge_mode[0] == $past(sfr_wdata[BIT_EDGE_A])
		&& edge_mode[1] == $past(sfr_wdata[BIT_EDGE_B]))
		else $error("sensitivity bits not taken");
	cfg_read_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && sfr_rd && sfr_addr == ADDR_PIN_CONFIG
		|=> sfr_rdata == $past(ext_irq_pin_config))
		else $error("pin config readback wrong");
	edge_read_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && sfr_rd && sfr_addr == ADDR_TIMER_CONTROL
		|=> sfr_rdata[BIT_EDGE_A] == $past(edge_mode[0])
		&& sfr_rdata[BIT_EDGE_B] == $past(edge_mode[1]))
		else $error("sensitivity bits read at wrong place");
	timer_control_reg_upper_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && sfr_rd && sfr_addr == ADDR_TIMER_CONTROL |=> sfr_rdata[7:4] == 4'h0)
		else $error("timer bits not read as zero");

	// selected pin, dedication and freezing
	map_a_level_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && !edge_mode[0]
		|=> ext_irq_a_pending == ($past(pin_sync[sel[0]]) == $past(pol[0])))
		else $error("input a level does not follow selected pin");
	map_b_level_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && !edge_mode[1]
		|=> ext_irq_b_pending == ($past(pin_sync[sel[1]]) == $past(pol[1])))
		else $error("input b level does not follow selected pin");
	excl_a_map_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en |=> ext_irq_a_exclusive == $past(skip_all[sel[0]]))
		else $error("input a dedicated flag wrong");
	excl_b_map_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en |=> ext_irq_b_exclusive == $past(skip_all[sel[1]]))
		else $error("input b dedicated flag wrong");
	sync_b_a: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en ##1 clk_en |=> pin_sync[7] == $past(port1_pins[7], 2))
		else $error("synchronised port 1 pin lags wrongly");
	sync_freeze_a: assert property (@(posedge clk) disable iff (!rst_b)
		!clk_en |=> $stable(pin_sync))
		else $error("synchroniser moved while frozen");
	cfg_freeze_a: assert property (@(posedge clk) disable iff (!rst_b)
		!clk_en |=> $stable(ext_irq_pin_config))
		else $error("pin config moved while frozen");
	excl_freeze_a: assert property (@(posedge clk) disable iff (!rst_b)
		!clk_en |=> $stable(ext_irq_a_exclusive) && $stable(ext_irq_b_exclusive))
		else $error("dedicated flags moved while frozen");
	rdata_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		!(clk_en && sfr_rd) |=> $stable(sfr_rdata))
		else $error("read data moved without a read");

endmodule : exirq_top

// ### bench/exirq_src_model.sv
`timescale 1ns/1ps
// external interrupt sources, one logic level per selectable port pin
module exirq_src_model (
	input wire logic clk,           // system clock
	output logic [5:0] port0_pins,  // port 0 pins 0..5
	output logic [7:6] port1_pins   // port 1 pins 6..7
);
	logic [7:0] pins;

	// one vector for all eight, so a select code is also the pin index
	assign port0_pins = pins[5:0];
	assign port1_pins = pins[7:6];

	// pins start high, which is idle for active-low inputs
	initial begin
		pins = 8'hFF;
	end

	// a level request stays put until the bench releases it after service,
	// so it is never dropped before it has been recognised
	task automatic drive(input int idx, input logic lvl);
		@(negedge clk);
		pins[idx] = lvl;
	endtask : drive
endmodule : exirq_src_model

// ### bench/tb_external_interrupt_and_priority.sv
`timescale 1ns/1ps
module tb_external_interrupt_and_priority;
	import exirq_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic clk_en = 1'b1;
	logic [7:0] sfr_addr = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] skip = 8'h00;
	logic ack_a = 1'b0;
	logic ack_b = 1'b0;
	logic [7:0] sfr_rdata;
	logic [7:0] source_priority;
	logic [5:0] port0_pins;
	logic [7:6] port1_pins;
	logic pend_a, pend_b, excl_a, excl_b;
	int fail_count = 0;
	int total_checks = 0;
	int cycles = 0;

	// 50 MHz system clock
	always #10 clk = ~clk;

	exirq_src_model i_src (.clk(clk), .port0_pins(port0_pins), .port1_pins(port1_pins));

	exirq_top i_dut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.port0_pins(port0_pins), .port1_pins(port1_pins), .skip_p0(skip[5:0]),
		.skip_p1(skip[7:6]), .vector_ack_a(ack_a), .vector_ack_b(ack_b),
		.ext_irq_a_pending(pend_a), .ext_irq_b_pending(pend_b),
		.ext_irq_a_exclusive(excl_a), .ext_irq_b_exclusive(excl_b),
		.source_priority(source_priority));

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up

	// hang guard, well above the few hundred cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			fail_count++;
			wrap_up();
		end
	end

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// one-cycle write strobe, launched off the sampling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask : wr

	// read data is registered, so it is settled by the following falling edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		d = sfr_rdata;
	endtask : rd

	task automatic ack(input logic a, input logic b);
		@(negedge clk);
		ack_a = a;
		ack_b = b;
		@(negedge clk);
		ack_a = 1'b0;
		ack_b = 1'b0;
	endtask : ack

	task automatic t_reset();
		logic [7:0] d;
		rd(ADDR_PRIORITY_TWO, d);
		chk("prio reset", d, 8'h00);
		rd(ADDR_PIN_CONFIG, d);
		chk("cfg reset", d, 8'h01);
		rd(ADDR_TIMER_CONTROL, d);
		chk("timer_control_reg reset", d, 8'h00);
		chk("pend reset", 8'({pend_b, pend_a}), 8'h00);
		$display("test reset done");
	endtask : t_reset

	// walking one through every priority bit, then an unmapped address
	task automatic t_prio();
		logic [7:0] d;
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_PRIORITY_TWO, 8'h01 << i);
			rd(ADDR_PRIORITY_TWO, d);
			chk("prio read", d, 8'h01 << i);
			chk("prio out", source_priority, 8'h01 << i);
		end
		wr(8'h77, 8'hFF);
		rd(8'h77, d);
		chk("unmapped", d, 8'h00);
		chk("prio kept", source_priority, 8'h80);
		$display("test priority done");
	endtask : t_prio

	// level mode through all eight select codes; a active low, b active high
	task automatic t_level();
		logic [7:0] d;
		for (int c = 0; c < 8; c++) begin
			i_src.drive(c, 1'b1);
			i_src.drive(7 - c, 1'b0);
			skip = 8'h01 << c;
			wr(ADDR_PIN_CONFIG, {1'b1, 3'(7 - c), 1'b0, 3'(c)});
			repeat (4) @(negedge clk);
			chk("lvl idle", 8'({pend_b, pend_a}), 8'h00);
			chk("exclusive", 8'({excl_b, excl_a}), 8'h01);
			i_src.drive(c, 1'b0);
			repeat (3) @(negedge clk);
			chk("lvl a", 8'({pend_b, pend_a}), 8'h01);
			i_src.drive(7 - c, 1'b1);
			repeat (3) @(negedge clk);
			// software clear and vectoring must not touch a level flag
			wr(ADDR_TIMER_CONTROL, 8'h00);
			ack(1'b1, 1'b1);
			rd(ADDR_TIMER_CONTROL, d);
			chk("lvl timer_control_reg", d, 8'h0A);
			i_src.drive(c, 1'b1);
			i_src.drive(7 - c, 1'b0);
			repeat (3) @(negedge clk);
			chk("lvl off", 8'({pend_b, pend_a}), 8'h00);
		end
		$display("test level done");
	endtask : t_level

	// edge mode: a falling on pin 0, b rising on pin 1
	task automatic t_edge();
		logic [7:0] d;
		i_src.drive(0, 1'b1);
		i_src.drive(1, 1'b0);
		wr(ADDR_PIN_CONFIG, 8'h90);
		repeat (4) @(negedge clk);
		wr(ADDR_TIMER_CONTROL, 8'h05);
		repeat (4) @(negedge clk);
		rd(ADDR_TIMER_CONTROL, d);
		chk("edge idle", d, 8'h05);
		i_src.drive(0, 1'b0);
		repeat (3) @(negedge clk);
		chk("edge a set", 8'({pend_b, pend_a}), 8'h01);
		i_src.drive(0, 1'b1);
		repeat (3) @(negedge clk);
		chk("edge a holds", 8'({pend_b, pend_a}), 8'h01);
		ack(1'b1, 1'b0);
		chk("ack clears a", 8'({pend_b, pend_a}), 8'h00);
		i_src.drive(1, 1'b1);
		repeat (3) @(negedge clk);
		chk("edge b set", 8'({pend_b, pend_a}), 8'h02);
		// writing zero to the pending bit is the software clear path
		wr(ADDR_TIMER_CONTROL, 8'h05);
		i_src.drive(1, 1'b0);
		repeat (3) @(negedge clk);
		chk("b cleared", 8'({pend_b, pend_a}), 8'h00);
		i_src.drive(0, 1'b0);
		repeat (3) @(negedge clk);
		ack(1'b0, 1'b1);
		chk("ack b only", 8'({pend_b, pend_a}), 8'h01);
		$display("test edge done");
	endtask : t_edge

	// clock enable low freezes everything: pin edges wait, while acks and writes made during the freeze are dropped
	task automatic t_freeze();
		@(negedge clk);
		clk_en = 1'b0;
		i_src.drive(1, 1'b1);
		ack(1'b1, 1'b0);
		wr(ADDR_PRIORITY_TWO, 8'h55);
		repeat (3) @(negedge clk);
		chk("frozen pend", 8'({pend_b, pend_a}), 8'h01);
		chk("frozen prio", source_priority, 8'h80);
		clk_en = 1'b1;
		repeat (3) @(negedge clk);
		chk("thawed edge", 8'({pend_b, pend_a}), 8'h03);
		$display("test freeze done");
	endtask : t_freeze

	// edge meeting a software clear in one cycle, then a reset in mid-run
	task automatic t_collide();
		logic [7:0] d;
		ack(1'b1, 1'b1);
		chk("both acked", 8'({pend_b, pend_a}), 8'h00);
		i_src.drive(0, 1'b1);
		repeat (3) @(negedge clk);
		i_src.drive(0, 1'b0);
		@(negedge clk);
		// write strobe lands on the edge that the synchronised edge reaches the flag
		wr(ADDR_TIMER_CONTROL, 8'h05);
		chk("set beats clear", 8'({pend_b, pend_a}), 8'h01);
		i_src.drive(0, 1'b1);
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		@(negedge clk);
		chk("pend after reset", 8'({pend_b, pend_a}), 8'h00);
		rd(ADDR_PRIORITY_TWO, d);
		chk("prio after reset", d, 8'h00);
		chk("prio out reset", source_priority, 8'h00);
		$display("test collide and reset done");
	endtask : t_collide

	initial begin
		repeat (6) @(negedge clk);
		rst_b = 1'b1;
		t_reset();
		t_prio();
		t_level();
		t_edge();
		t_freeze();
		t_collide();
		wrap_up();
	end
endmodule : tb_external_interrupt_and_priority
